// File: rtl/stream_scan_map.svh
// register offsets, field positions, codes and timing counts of the sequencer
`ifndef STREAM_SCAN_MAP_SVH
`define STREAM_SCAN_MAP_SVH
// 16-bit register addresses, big-endian word pairs (high word first)
`define SSQ_SETTLE_HI     16'h0fa8
`define SSQ_SETTLE_LO     16'h0fa9
`define SSQ_RES_HI        16'h0faa
`define SSQ_RES_LO        16'h0fab
`define SSQ_CAPTURE       16'h1323
`define SSQ_PERIOD_HI     16'h0f00
`define SSQ_PERIOD_LO     16'h0f01
`define SSQ_NUM_ADDR      16'h0f02
`define SSQ_BURST_HI      16'h0f03
`define SSQ_BURST_LO      16'h0f04
`define SSQ_OPTIONS       16'h0f05
`define SSQ_ENABLE        16'h0f06
`define SSQ_STATUS        16'h0f07
`define SSQ_ERROR         16'h0f08
`define SSQ_SCAN_COUNT_HI 16'h0f09
`define SSQ_SCAN_COUNT_LO 16'h0f0a
`define SSQ_LIST_BASE     16'h1000
// reset values
`define SSQ_SETTLE_RST    32'h0000_0000
`define SSQ_RES_RST       32'h0000_0000
`define SSQ_PERIOD_RST    32'h0000_2710
`define SSQ_BURST_RST     32'h0000_0000
// option bits
`define SSQ_OPT_TRIG      0
`define SSQ_OPT_EXTCLK    1
// status bits
`define SSQ_ST_ACTIVE     0
`define SSQ_ST_ARMED      1
`define SSQ_ST_RATE_HIGH  2
`define SSQ_ST_DERATED    3
`define SSQ_ST_HAS_IN     4
`define SSQ_ST_HAS_OUT    5
// error codes
`define SSQ_ERR_NONE      16'h0000
`define SSQ_ERR_OVERLAP   16'h0b7e
`define SSQ_ERR_BUSY      16'h0001
`define SSQ_ERR_RES       16'h0002
`define SSQ_ERR_CFG       16'h0003
// unsupported resolution window
`define SSQ_RES_BAD_LO    32'h0000_0009
`define SSQ_RES_BAD_HI    32'h0000_000c
// channel kind codes in bits 15:12 of a scan entry
`define SSQ_K_AIN         4'h0
`define SSQ_K_PORT        4'h1
`define SSQ_K_LINE        4'h2
`define SSQ_K_EF          4'h3
`define SSQ_K_SLOW        4'h4
`define SSQ_K_CORE        4'h5
`define SSQ_K_CAPT        4'h6
`define SSQ_K_OUT         4'h7
`define SSQ_NUM_LINES     23
// timing: clock period and one microsecond in picoseconds
`define SSQ_CLK_PERIOD_PS 4000
`define SSQ_US_PS         1000000
`define SSQ_US_CYCLES     (`SSQ_US_PS / `SSQ_CLK_PERIOD_PS)
`define SSQ_AUTO_SETTLE_US 16'h0001
`endif

// File: rtl/stream_scan_pkg.sv
// types shared by the stream scan sequencer
package stream_scan_pkg;
`include "stream_scan_map.svh"
  // kind of channel named by one scan entry
  typedef enum logic [3:0] {
    k_ain  = `SSQ_K_AIN,
    k_port = `SSQ_K_PORT,
    k_line = `SSQ_K_LINE,
    k_ef   = `SSQ_K_EF,
    k_slow = `SSQ_K_SLOW,
    k_core = `SSQ_K_CORE,
    k_capt = `SSQ_K_CAPT,
    k_out  = `SSQ_K_OUT
  } chan_kind_e;
  // one scan list entry
  typedef struct packed {
    chan_kind_e  kind;
    logic [11:0] index;
  } scan_entry_s;
  // conversion request toward the converter
  typedef struct packed {
    logic [11:0] chan;
    logic [3:0]  res;
  } adc_req_s;
  // one-hot sequencer states
  typedef enum logic [5:0] {
    s_idle   = 6'h01,
    s_fetch  = 6'h02,
    s_settle = 6'h04,
    s_start  = 6'h08,
    s_conv   = 6'h10,
    s_emit   = 6'h20
  } seq_state_e;
endpackage

// File: rtl/stream_scan_sequencer.sv
// stream scan sequencer with its sample fifo
//
// Functional notes
// - one session only; second start refused
// - each pulse scans whole list in order
// - internal timer makes constant-rate scan pulses
// - scans repeat from start until stopped
// - command reads ok; analog refused while streaming
// - burst mode stops after configured scan count
// - optional trigger hold-off on higher-rate variant
// - optional external scan clock, higher-rate variant
// - higher variant: 100k samples/s, derate flagged
// - lower variant: 40k samples/s, derate flagged
// - mode follows input/output kinds in list
// - analog, ports, lines, features, timers, capture
// - samples are 16-bit, analog raw code
// - 32-bit value: low sent, high captured
// - capture may repeat; shows latest high half
// - settle wait after mux, except first entry
// - settle resets zero; below one means auto
// - stream resolution index drives conversions
// - resolution nine to twelve refused for stream
// - converter keeps its own range settings
// - pulse during scan stops, error 2942
// - first scan one period after enable

// sample fifo, flip-flop storage
module stream_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // filling side
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];  // storage
  logic [PW-1:0]    wr_ff;           // write pointer
  logic [PW-1:0]    rd_ff;           // read pointer
  logic [PW:0]      cnt_ff;          // fill level
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  wire [PW-1:0]     last = PW'(DEPTH - 1);

  assign in_ready  = (cnt_ff != (PW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];

  // store on push
  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wr_ff] <= in_data;
  end

  // pointers and level
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ff <= (wr_ff == last) ? '0 : wr_ff + 1'b1;
      if (pop)
        rd_ff <= (rd_ff == last) ? '0 : rd_ff + 1'b1;
      cnt_ff <= cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

`include "stream_scan_map.svh"
module stream_scan_sequencer
  import stream_scan_pkg::*;
#(
  parameter int MAX_ADDR   = 16,
  parameter int HIGH_RATE  = 1,
  parameter int CLK_HZ     = 250000000,
  parameter int MAX_RATE   = (HIGH_RATE != 0) ? 100000 : 40000,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // register port, 16-bit words
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  output      logic [15:0] reg_rdata,
  output      logic        reg_ack,
  // command-response analog read arbitration
  input  wire logic        cr_ain_req,
  output      logic        cr_ain_refused,
  // converter
  output      logic        adc_start,
  output      adc_req_s    adc_req,
  input  wire logic        adc_done,
  input  wire logic [15:0] adc_code,
  input  wire logic        ain_all_wide_range,
  // sampled sources
  input  wire logic [15:0] port_state_word,
  input  wire logic [22:0] digital_line_state,
  output      logic [4:0]  ef_sel,
  input  wire logic [31:0] extended_feature_result,
  input  wire logic [31:0] slow_tick_timer,
  input  wire logic [31:0] core_timer,
  // stream-out strobe
  output      logic        out_strobe,
  output      logic [11:0] out_index,
  // trigger and external scan clock
  input  wire logic        trigger_in,
  input  wire logic        ext_clk_in,
  // sample stream toward the link
  output      logic        smp_valid,
  input  wire logic        smp_ready,
  output      logic [15:0] smp_data,
  // session state
  output      logic        stream_active,
  output      logic        scan_overrun_error
);
  localparam int AW = $clog2(MAX_ADDR);
  localparam int UW = $clog2(`SSQ_US_CYCLES);

  // configuration registers
  logic [31:0]   settle_ff;            // mux_settle_time, us
  logic [31:0]   res_ff;               // stream_resolution_select
  logic [31:0]   period_ff;            // scan period in clocks
  logic [31:0]   burst_ff;             // scans per burst, 0 = endless
  logic [AW:0]   num_ff;               // scan list length
  logic [1:0]    opt_ff;               // trigger, external clock
  logic [15:0]   list_ff [MAX_ADDR];   // scan list
  // session and sequencer state
  logic          active_ff;
  logic          armed_ff;
  logic [15:0]   err_ff;
  logic [15:0]   capture_ff;           // upper_half_capture
  logic [31:0]   per_cnt_ff;
  logic [31:0]   scan_cnt_ff;
  logic          ext_q_ff;
  logic          trig_q_ff;
  logic [UW-1:0] us_cnt_ff;
  logic [15:0]   settle_cnt_ff;
  logic [AW-1:0] idx_ff;
  logic [15:0]   sample_ff;
  logic          rate_high_ff;
  seq_state_e    state_ff;
  logic [15:0]   rdata_ff;
  logic          ack_ff;
  // next values
  seq_state_e    nxt_state;
  logic [AW-1:0] nxt_idx;
  logic [15:0]   nxt_sample;
  logic [15:0]   nxt_capture;
  logic [15:0]   nxt_settle_cnt;
  logic          scan_end;
  logic [15:0]   rd_mux;
  logic          smp_in_ready;         // fifo has room for a sample

  // write decode
  wire wr_en     = reg_wr && (reg_addr == `SSQ_ENABLE);
  wire start_req = wr_en && reg_wdata[0];
  wire stop_req  = wr_en && !reg_wdata[0];
  wire err_clr   = reg_wr && (reg_addr == `SSQ_ERROR);
  wire res_bad   = (res_ff >= `SSQ_RES_BAD_LO) &&
                   (res_ff <= `SSQ_RES_BAD_HI);
  wire cfg_bad   = (num_ff == '0) || (num_ff > (AW+1)'(MAX_ADDR));
  wire start_ok  = start_req && !active_ff && !res_bad && !cfg_bad;

  // scan list: stream-in and stream-out presence
  logic [MAX_ADDR-1:0] is_out;
  logic [MAX_ADDR-1:0] is_in;
  genvar g;
  generate
    for (g = 0; g < MAX_ADDR; g++)
    begin : g_list
      wire used = (AW+1)'(g) < num_ff;
      assign is_out[g] = used && (list_ff[g][15:12] == `SSQ_K_OUT);
      assign is_in[g]  = used && (list_ff[g][15:12] != `SSQ_K_OUT);
      // entry write
      always_ff @(posedge clk or posedge sys_rst)
      begin
        if (sys_rst)
          list_ff[g] <= 16'h0000;
        else if (reg_wr && (reg_addr == `SSQ_LIST_BASE + 16'(g)))
          list_ff[g] <= reg_wdata;
      end
    end
  endgenerate

  // scan pulse sources
  wire use_ext   = (HIGH_RATE != 0) && opt_ff[`SSQ_OPT_EXTCLK];
  wire use_trig  = (HIGH_RATE != 0) && opt_ff[`SSQ_OPT_TRIG];
  wire ext_rise  = ext_clk_in && !ext_q_ff;
  wire trig_rise = trigger_in && !trig_q_ff;
  wire [31:0] period_eff = (period_ff == '0) ? 32'h1 : period_ff;
  wire int_pulse = (per_cnt_ff == period_eff - 32'h1);
  wire scan_pulse = active_ff && !armed_ff &&
                    (use_ext ? ext_rise : int_pulse);
  wire overlap   = scan_pulse && (state_ff != s_idle);
  wire scan_go   = scan_pulse && (state_ff == s_idle);
  wire burst_end = scan_end && (burst_ff != '0) &&
                   (scan_cnt_ff + 32'h1 == burst_ff);
  wire us_tick   = (us_cnt_ff == UW'(`SSQ_US_CYCLES - 1));

  // current entry and its 32-bit value
  scan_entry_s entry;
  assign entry = scan_entry_s'(list_ff[idx_ff]);
  assign ef_sel = entry.index[4:0];
  wire line_ok = entry.index < 12'(`SSQ_NUM_LINES);
  wire [31:0] wide_val =
      (entry.kind == k_ef)   ? extended_feature_result :
      (entry.kind == k_slow) ? slow_tick_timer :
      core_timer;
  wire is_wide = (entry.kind == k_ef) || (entry.kind == k_slow) ||
                 (entry.kind == k_core);
  wire [15:0] narrow_val =
      (entry.kind == k_port) ? port_state_word :
      (entry.kind == k_line) ? {15'h0000, line_ok &&
                                digital_line_state[entry.index[4:0]]} :
      capture_ff;
  wire last_entry = ((AW+1)'(idx_ff) == num_ff - (AW+1)'(1));
  // auto settle when configured below one microsecond
  wire [15:0] settle_us = (settle_ff == '0) ? `SSQ_AUTO_SETTLE_US :
                          (|settle_ff[31:16]) ? 16'hffff :
                          settle_ff[15:0];

  // sequencer next state
  always_comb
  begin
    nxt_state      = state_ff;
    nxt_idx        = idx_ff;
    nxt_sample     = sample_ff;
    nxt_capture    = capture_ff;
    nxt_settle_cnt = settle_cnt_ff;
    scan_end       = 1'b0;
    case (state_ff)
      s_idle:
      begin
        if (scan_go)
        begin
          nxt_idx   = '0;
          nxt_state = s_fetch;
        end
      end
      s_fetch:
      begin
        // analog entries convert; an analog entry at list index 0 skips the mux wait
        if (entry.kind == k_ain)
        begin
          nxt_settle_cnt = settle_us;
          nxt_state = (idx_ff == '0) ? s_start : s_settle;
        end
        else if (entry.kind == k_out)
        begin
          // output entry yields no sample
          if (last_entry)
          begin
            scan_end  = 1'b1;
            nxt_state = s_idle;
          end
          else
            nxt_idx = idx_ff + 1'b1;
        end
        else if (is_wide)
        begin
          nxt_sample  = wide_val[15:0];
          nxt_capture = wide_val[31:16];
          nxt_state   = s_emit;
        end
        else
        begin
          nxt_sample = narrow_val;
          nxt_state  = s_emit;
        end
      end
      s_settle:
      begin
        // count whole microseconds after the mux switch
        if (us_tick)
          nxt_settle_cnt = settle_cnt_ff - 16'h0001;
        if (settle_cnt_ff == 16'h0000)
          nxt_state = s_start;
      end
      s_start:
        nxt_state = s_conv;
      s_conv:
      begin
        if (adc_done)
        begin
          nxt_sample = adc_code;
          nxt_state  = s_emit;
        end
      end
      s_emit:
      begin
        // fifo full stalls the scan here
        if (smp_in_ready)
        begin
          if (last_entry)
          begin
            scan_end  = 1'b1;
            nxt_state = s_idle;
          end
          else
          begin
            nxt_idx   = idx_ff + 1'b1;
            nxt_state = s_fetch;
          end
        end
      end
      default:
        nxt_state = s_idle;
    endcase
    // a stopped session drops the scan in flight
    if (!active_ff || overlap)
      nxt_state = s_idle;
  end

  // converter and strobe outputs
  assign adc_start      = (state_ff == s_start);
  assign adc_req        = '{chan: entry.index, res: res_ff[3:0]};
  assign out_strobe     = (state_ff == s_fetch) && (entry.kind == k_out);
  assign out_index      = entry.index;
  assign cr_ain_refused = cr_ain_req && active_ff;
  assign stream_active  = active_ff;
  assign scan_overrun_error = (err_ff == `SSQ_ERR_OVERLAP);
  assign reg_rdata      = rdata_ff;
  assign reg_ack        = ack_ff;

  // sample fifo toward the link
  stream_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (state_ff == s_emit && active_ff),
    .in_ready  (smp_in_ready),
    .in_data   (sample_ff),
    .out_valid (smp_valid),
    .out_ready (smp_ready),
    .out_data  (smp_data)
  );

  // rate check: addresses times scan rate against the limit
  wire [63:0] rate_lhs = 64'(num_ff) * 64'(CLK_HZ);
  wire [63:0] rate_rhs = 64'(MAX_RATE) * 64'(period_eff);
  wire derated = (num_ff > (AW+1)'(1)) && ((res_ff > 32'h1) ||
                 ((HIGH_RATE != 0) && !ain_all_wide_range));

  // register read mux
  always_comb
  begin
    rd_mux = 16'h0000;
    case (reg_addr)
      `SSQ_SETTLE_HI:     rd_mux = settle_ff[31:16];
      `SSQ_SETTLE_LO:     rd_mux = settle_ff[15:0];
      `SSQ_RES_HI:        rd_mux = res_ff[31:16];
      `SSQ_RES_LO:        rd_mux = res_ff[15:0];
      `SSQ_CAPTURE:       rd_mux = capture_ff;
      `SSQ_PERIOD_HI:     rd_mux = period_ff[31:16];
      `SSQ_PERIOD_LO:     rd_mux = period_ff[15:0];
      `SSQ_NUM_ADDR:      rd_mux = 16'(num_ff);
      `SSQ_BURST_HI:      rd_mux = burst_ff[31:16];
      `SSQ_BURST_LO:      rd_mux = burst_ff[15:0];
      `SSQ_OPTIONS:       rd_mux = {14'h0000, opt_ff};
      `SSQ_ENABLE:        rd_mux = {15'h0000, active_ff};
      `SSQ_STATUS:        rd_mux = {10'h000, |is_out, |is_in, derated,
                                    rate_high_ff, armed_ff, active_ff};
      `SSQ_ERROR:         rd_mux = err_ff;
      `SSQ_SCAN_COUNT_HI: rd_mux = scan_cnt_ff[31:16];
      `SSQ_SCAN_COUNT_LO: rd_mux = scan_cnt_ff[15:0];
      default:
      begin
        // scan list window, others read zero
        if (reg_addr >= `SSQ_LIST_BASE &&
            reg_addr < `SSQ_LIST_BASE + 16'(MAX_ADDR))
          rd_mux = list_ff[AW'(reg_addr - `SSQ_LIST_BASE)];
      end
    endcase
  end

  // configuration writes
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      settle_ff <= `SSQ_SETTLE_RST;
      res_ff    <= `SSQ_RES_RST;
      period_ff <= `SSQ_PERIOD_RST;
      burst_ff  <= `SSQ_BURST_RST;
      num_ff    <= (AW+1)'(1);
      opt_ff    <= 2'h0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `SSQ_SETTLE_HI: settle_ff[31:16] <= reg_wdata;
        `SSQ_SETTLE_LO: settle_ff[15:0]  <= reg_wdata;
        `SSQ_RES_HI:    res_ff[31:16]    <= reg_wdata;
        `SSQ_RES_LO:    res_ff[15:0]     <= reg_wdata;
        `SSQ_PERIOD_HI: period_ff[31:16] <= reg_wdata;
        `SSQ_PERIOD_LO: period_ff[15:0]  <= reg_wdata;
        `SSQ_NUM_ADDR:  num_ff           <= reg_wdata[AW:0];
        `SSQ_BURST_HI:  burst_ff[31:16]  <= reg_wdata;
        `SSQ_BURST_LO:  burst_ff[15:0]   <= reg_wdata;
        `SSQ_OPTIONS:   opt_ff           <= reg_wdata[1:0];
        default:        opt_ff           <= opt_ff;
      endcase
    end
  end

  // session control and error code
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      active_ff    <= 1'b0;
      armed_ff     <= 1'b0;
      err_ff       <= `SSQ_ERR_NONE;
      rate_high_ff <= 1'b0;
    end
    else
    begin
      if (start_ok)
      begin
        active_ff    <= 1'b1;
        armed_ff     <= use_trig;
        rate_high_ff <= !use_ext && (rate_lhs > rate_rhs);
      end
      else if (stop_req || overlap || burst_end)
        active_ff <= 1'b0;
      if (armed_ff && trig_rise)
        armed_ff <= 1'b0;
      // new error wins over software clear
      if (overlap)
        err_ff <= `SSQ_ERR_OVERLAP;
      else if (start_req && active_ff)
        err_ff <= `SSQ_ERR_BUSY;
      else if (start_req && res_bad)
        err_ff <= `SSQ_ERR_RES;
      else if (start_req && cfg_bad)
        err_ff <= `SSQ_ERR_CFG;
      else if (err_clr)
        err_ff <= `SSQ_ERR_NONE;
    end
  end

  // scan timer, edge history, scan count
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      per_cnt_ff  <= 32'h0;
      scan_cnt_ff <= 32'h0;
      ext_q_ff    <= 1'b0;
      trig_q_ff   <= 1'b0;
      us_cnt_ff   <= '0;
    end
    else
    begin
      ext_q_ff  <= ext_clk_in;
      trig_q_ff <= trigger_in;
      // timer restarts at enable so first pulse is one period later
      if (!active_ff || armed_ff || start_ok || int_pulse)
        per_cnt_ff <= 32'h0;
      else
        per_cnt_ff <= per_cnt_ff + 32'h1;
      if (start_ok)
        scan_cnt_ff <= 32'h0;
      else if (scan_end)
        scan_cnt_ff <= scan_cnt_ff + 32'h1;
      // microsecond divider aligned to the settle start
      if (state_ff != s_settle || us_tick)
        us_cnt_ff <= '0;
      else
        us_cnt_ff <= us_cnt_ff + 1'b1;
    end
  end

  // sequencer registers and register read answer
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff      <= s_idle;
      idx_ff        <= '0;
      sample_ff     <= 16'h0000;
      capture_ff    <= 16'h0000;
      settle_cnt_ff <= 16'h0000;
      rdata_ff      <= 16'h0000;
      ack_ff        <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      idx_ff        <= nxt_idx;
      sample_ff     <= nxt_sample;
      capture_ff    <= nxt_capture;
      settle_cnt_ff <= nxt_settle_cnt;
      ack_ff        <= reg_rd || reg_wr;
      if (reg_rd)
        rdata_ff <= rd_mux;
    end
  end
endmodule

// File: verification/stream_scan_sequencer_chk.sv
// port assertions for the stream scan sequencer
`include "stream_scan_map.svh"
module stream_scan_sequencer_chk
  import stream_scan_pkg::*;
(
  // clock, reset and register port
  input wire logic        clk, sys_rst, reg_wr, reg_rd, reg_ack,
  input wire logic [15:0] reg_addr, reg_wdata, smp_data,
  // session, converter and stream
  input wire logic        cr_ain_req, cr_ain_refused, adc_start,
  input wire logic        smp_valid, smp_ready, stream_active,
  input wire logic        scan_overrun_error,
  input wire adc_req_s    adc_req,
  input wire logic [4:0]  ef_sel,
  input wire logic [11:0] out_index
);
  logic en_wr; // write to the enable control
  assign en_wr = reg_wr && (reg_addr == `SSQ_ENABLE);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_AIN_REFUSE: assert property (
    cr_ain_refused == (cr_ain_req && stream_active)) else $error("ain open");
  AST_CMD_ACK: assert property (
    (reg_wr || reg_rd) |=> reg_ack) else $error("no ack");
  AST_SECOND_START: assert property (
    stream_active && en_wr && reg_wdata == 16'h0001 |=> stream_active)
    else $error("second start broke session");
  AST_STOP: assert property (
    en_wr && reg_wdata == 16'h0000 |=> !stream_active) else $error("no stop");
  AST_OVERRUN_STOPS: assert property (
    scan_overrun_error |-> !stream_active) else $error("overrun kept running");
  AST_START_PULSE: assert property (
    adc_start |=> !adc_start && $stable(adc_req.chan) && $stable(ef_sel))
    else $error("conversion request not held");
  AST_SAMPLE_HOLD: assert property (
    smp_valid && !smp_ready |=> smp_valid && $stable(smp_data))
    else $error("sample lost under stall");
  AST_FIRST_SCAN_LATE: assert property (
    $rose(stream_active) |-> !adc_start [*2]) else $error("scan at enable");
  cover property ($rose(stream_active));
  cover property (smp_valid && smp_ready);
  cover property ($rose(scan_overrun_error));
endmodule
bind stream_scan_sequencer stream_scan_sequencer_chk chk (.clk, .sys_rst,
  .reg_wr, .reg_rd, .reg_ack, .reg_addr, .reg_wdata, .smp_data, .cr_ain_req,
  .cr_ain_refused, .adc_start, .smp_valid, .smp_ready, .stream_active,
  .scan_overrun_error, .adc_req, .ef_sel, .out_index);

// File: verification/scan_partner_model.sv
// converter and sample sink standing at the sequencer's far side
module scan_partner_model
  import stream_scan_pkg::*;
(
  // clock and pace
  input  wire logic        clk,
  input  wire logic        slow,
  // converter side
  input  wire logic        adc_start,
  input  wire adc_req_s    adc_req,
  output      logic        adc_done,
  output      logic [15:0] adc_code,
  // sink side
  output      logic        smp_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  wait_cnt = '0; // cycles left of the conversion
  logic [11:0] chan     = '0; // channel under conversion
  logic [7:0]  tick     = '0; // free count for noise and stalls
  // code only valid with done; noise otherwise exposes a late sample
  assign adc_code  = adc_done ? {4'ha, chan} : {tick, ~tick};
  assign smp_ready = !slow || tick[1];
  // conversion timer, slow pace stretches it
  always @(posedge clk)
  begin
    tick     <= tick + 8'h01;
    adc_done <= (wait_cnt == 4'h1);
    if (adc_start)
    begin
      wait_cnt <= slow ? 4'h6 : 4'h2;
      chan     <= adc_req.chan;
    end
    else if (wait_cnt != 4'h0)
      wait_cnt <= wait_cnt - 4'h1;
  end
endmodule

// File: verification/stream_scan_sequencer_bench.sv
// self-checking bench for the stream scan sequencer
`include "stream_scan_map.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module stream_scan_sequencer_bench;
  import stream_scan_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, rdp = 0, slow = 0;
  logic        cr_ain_req = 0, trigger_in = 0, ext_clk_in = 0;
  logic        ain_all_wide_range = 1;
  logic [15:0] reg_addr = '0, reg_wdata = '0, port_state_word = '0, ex;
  logic [15:0] lf = 16'h004a; // random source seed
  logic [22:0] digital_line_state = '0;
  logic [31:0] core_timer = '0, slow_tick_timer = '0;
  logic [31:0] extended_feature_result = '0;
  logic        reg_ack, cr_ain_refused, adc_start, adc_done, out_strobe;
  logic        smp_valid, smp_ready, stream_active, scan_overrun_error;
  logic [15:0] reg_rdata, adc_code, smp_data;
  logic [4:0]  ef_sel;
  logic [11:0] out_index;
  adc_req_s    adc_req;
  logic [15:0] rq[$], sq[$]; // expected reads and samples
  int          error_cnt = 0, check_count = 0, osc = 0;
  stream_scan_sequencer dut (.*);
  scan_partner_model far (.clk, .slow, .adc_start, .adc_req, .adc_done,
    .adc_code, .smp_ready);
  always #2 clk = ~clk;
  function automatic logic [15:0] nxt_lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // one register word access, strobe then a quiet cycle
  task automatic reg_op(input logic w, input logic [15:0] a, d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = w;
    reg_rd    = !w;
    @(posedge clk) #1;
    reg_wr = 0;
    reg_rd = 0;
    @(posedge clk) #1;
  endtask
  task automatic wr(input logic [15:0] a, d);
    reg_op(1, a, d);
  endtask
  task automatic rd(input logic [15:0] a, e);
    rq.push_back(e);
    reg_op(0, a, 16'h0000);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // result watcher: oldest note against each answer
  always @(posedge clk)
  begin
    if (rdp && reg_ack)
    begin
      ex = rq.size() ? rq.pop_front() : 'x;
      `CHK("reg_rdata", ex, reg_rdata)
    end
    if (smp_valid && smp_ready)
    begin
      ex = sq.size() ? sq.pop_front() : 'x;
      `CHK("smp_data", ex, smp_data)
    end
    if (out_strobe)
    begin
      osc++;
      `CHK("out_index", 12'h005, out_index)
    end
    rdp <= reg_rd;
  end
  initial
  begin
    #200us;
    error_cnt++;
    results();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    #1 sys_rst = 0;
    lf = nxt_lfsr(lf);
    port_state_word = lf;
    lf = nxt_lfsr(lf);
    core_timer = {lf, nxt_lfsr(lf)};
    slow_tick_timer = {lf, port_state_word};
    extended_feature_result = ~slow_tick_timer;
    digital_line_state = core_timer[22:0];
    rd(`SSQ_SETTLE_LO, 16'h0000);
    for (int r = 9; r <= 12; r++)
    begin
      wr(`SSQ_RES_LO, 16'(r));
      wr(`SSQ_ENABLE, 16'h0001);
      rd(`SSQ_ERROR, `SSQ_ERR_RES);
      rd(`SSQ_ENABLE, 16'h0000);
    end
    wr(`SSQ_RES_LO, 16'h0000);
    wr(`SSQ_LIST_BASE, {`SSQ_K_CORE, 12'h000});
    wr(`SSQ_LIST_BASE + 16'h1, {`SSQ_K_CAPT, 12'h000});
    wr(`SSQ_LIST_BASE + 16'h2, {`SSQ_K_PORT, 12'h000});
    wr(`SSQ_LIST_BASE + 16'h3, {`SSQ_K_AIN, 12'h003});
    wr(`SSQ_LIST_BASE + 16'h4, {`SSQ_K_OUT, 12'h005});
    wr(`SSQ_NUM_ADDR, 16'h0005);
    wr(`SSQ_PERIOD_LO, 16'h30d4);
    wr(`SSQ_BURST_LO, 16'h0002);
    repeat (2) sq = {sq, core_timer[15:0], core_timer[31:16],
      port_state_word, 16'ha003};
    slow = 1;
    cr_ain_req = 1;
    wr(`SSQ_ENABLE, 16'h0001);
    wr(`SSQ_ENABLE, 16'h0001);
    rd(`SSQ_ERROR, `SSQ_ERR_BUSY);
    rd(`SSQ_ENABLE, 16'h0001);
    rd(`SSQ_STATUS, 16'h0031);
    `CHK("cr_ain_refused", 1'b1, cr_ain_refused)
    for (int i = 0; i < 30000 && stream_active; i++) @(posedge clk);
    repeat (40) @(posedge clk);
    rd(`SSQ_ENABLE, 16'h0000);
    rd(`SSQ_CAPTURE, core_timer[31:16]);
    `CHK("strobes", 2, osc)
    `CHK("cr_ain_refused", 1'b0, cr_ain_refused)
    `CHK("queued", 32'h0, 32'(sq.size()))
    wr(`SSQ_ERROR, 16'h0000);
    wr(`SSQ_LIST_BASE, {`SSQ_K_AIN, 12'h003});
    wr(`SSQ_NUM_ADDR, 16'h0001);
    wr(`SSQ_OPTIONS, 16'h0003);
    wr(`SSQ_BURST_LO, 16'h0000);
    wr(`SSQ_ENABLE, 16'h0001);
    rd(`SSQ_STATUS, 16'h0013);
    trigger_in = 1;
    for (int i = 0; i < 100 && !scan_overrun_error; i++)
    begin
      @(posedge clk) #1;
      ext_clk_in = i[1];
    end
    rd(`SSQ_ERROR, `SSQ_ERR_OVERLAP);
    rd(`SSQ_ENABLE, 16'h0000);
    wr(`SSQ_ENABLE, 16'h0000);
    repeat (20) @(posedge clk);
    results();
  end
endmodule
